// [hdl/scf_pkg.sv]
// constants for the port b smbus control and status flag register
package scf_pkg;
    // register location in special-function space
    localparam logic [7:0] CTRL_ADDR = 8'hC0;
    localparam logic [3:0] CTRL_PAGE = 4'hF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // field positions
    localparam int MASTER_BIT = 7;
    localparam int TXDIR_BIT = 6;
    localparam int START_BIT = 5;
    localparam int STOP_BIT = 4;
    localparam int ACKRQ_BIT = 3;
    localparam int ARBL_BIT = 2;
    localparam int ACK_BIT = 1;
    localparam int EVENT_BIT = 0;
    // bits that software may write
    localparam logic [7:0] WRITE_MASK = 8'h33;
    // engine event indices, one toggle wire each across the clock boundary
    localparam int EV_START_GEN = 0;
    localparam int EV_STOP_GEN = 1;
    localparam int EV_START_DET = 2;
    localparam int EV_ADDR_RX = 3;
    localparam int EV_RSTART_DET = 4;
    localparam int EV_STOP_DET = 5;
    localparam int EV_BYTE_RX = 6;
    localparam int EV_BYTE_TX_ACK = 7;
    localparam int EV_ACK_DONE = 8;
    localparam int EV_SCL_LOST = 9;
    localparam int EV_SDA_LOST = 10;
    localparam int EV_ADDR_NACK = 11;
    localparam int EV_FRAME_BEGIN = 12;
    localparam int NUM_EV = 13;
    // levels from engine: incoming ack low, addressed as slave
    localparam int LV_ACK_LOW = 0;
    localparam int LV_ADDRESSED = 1;
    localparam int NUM_LV = 2;
    // levels to engine
    localparam int CT_HOLD_SCL = 0;
    localparam int CT_START_REQ = 1;
    localparam int CT_STOP_REQ = 2;
    localparam int CT_ACK_OUT = 3;
    localparam int CT_HW_ACK = 4;
    localparam int NUM_CT = 5;
endpackage

// [hdl/scf_ctrl.sv]
// control and status flag register of the second smbus port
`timescale 1ns/1ps
module scf_ctrl #(
    parameter int NEV = scf_pkg::NUM_EV,
    parameter int NLV = scf_pkg::NUM_LV,
    parameter int NCT = scf_pkg::NUM_CT
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rstn,
    // special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic irq,
    // side inputs from the rest of the port
    input wire logic data_reg_wr,
    input wire logic hardware_ack_enable,
    // link-side engine on its own clock
    input wire logic link_clk,
    input wire logic link_rstn,
    input wire logic [NEV-1:0] link_event,
    input wire logic [NLV-1:0] link_level,
    output logic link_hold_scl,
    output logic link_start_req,
    output logic link_stop_req,
    output logic link_ack_out,
    output logic link_hw_ack
);
    // system-domain state
    typedef struct packed {
        logic [NEV-1:0] ev_s1;
        logic [NEV-1:0] ev_s2;
        logic [NEV-1:0] ev_s3;
        logic [NEV-1:0] ev_acc;
        logic [NLV-1:0] lv_s1;
        logic [NLV-1:0] lv_s2;
        logic [NLV-1:0] lv_s3;
        logic [NLV-1:0] lv_acc;
        logic [7:0] port_b_control_reg;
        logic data_written;
        logic ignore_slave;
        logic [7:0] rdata;
        logic irq;
    } scf_sys_t;

    // link-domain state
    typedef struct packed {
        logic [NEV-1:0] tog;
        logic [NCT-1:0] ct_s1;
        logic [NCT-1:0] ct_s2;
        logic [NCT-1:0] ct_s3;
        logic [NCT-1:0] ct_out;
    } scf_link_t;

    scf_sys_t s_q, s_d;
    scf_link_t l_q, l_d;
    logic [NEV-1:0] ev;
    logic [NCT-1:0] ctl_level;

    // byte write hits the register, or a bit write hits one of its bits
    function automatic logic [7:0] write_lanes(input logic [7:0] addr, input logic [3:0] page,
                                               input logic byte_wr, input logic bit_wr);
        logic [7:0] m;
        m = 8'h00;
        if (page == scf_pkg::CTRL_PAGE) begin
            if (byte_wr && addr == scf_pkg::CTRL_ADDR) begin
                m = 8'hFF;
            end else if (bit_wr && addr[7:3] == scf_pkg::CTRL_ADDR[7:3]) begin
                m = 8'h01 << addr[2:0];
            end
        end
        return m;
    endfunction

    // event accepted once second and third stages agree and differ from last seen
    for (genvar i = 0; i < NEV; i++) begin : g_ev
        assign ev[i] = (s_q.ev_s2[i] == s_q.ev_s3[i]) && (s_q.ev_s3[i] != s_q.ev_acc[i]);
    end

    // system-domain next state
    always_comb begin
        logic [7:0] r;
        logic [7:0] wm;
        logic [7:0] wv;
        logic lost;
        logic stop_loss;
        logic slave_ok;
        logic addr_ev;
        logic brx_ev;
        logic sw_si_clr;
        logic si_set;
        r = s_q.port_b_control_reg;
        wm = 8'h00;
        wv = 8'h00;
        lost = 1'b0;
        stop_loss = 1'b0;
        slave_ok = 1'b0;
        addr_ev = 1'b0;
        brx_ev = 1'b0;
        sw_si_clr = 1'b0;
        si_set = 1'b0;
        s_d = s_q;
        // three-stage crossing, first stage read only by the second
        s_d.ev_s1 = l_q.tog;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ev_s3 = s_q.ev_s2;
        s_d.lv_s1 = link_level;
        s_d.lv_s2 = s_q.lv_s1;
        s_d.lv_s3 = s_q.lv_s2;
        for (int i = 0; i < NEV; i++) begin
            if (s_q.ev_s2[i] == s_q.ev_s3[i]) begin
                s_d.ev_acc[i] = s_q.ev_s3[i];
            end
        end
        for (int i = 0; i < NLV; i++) begin
            if (s_q.lv_s2[i] == s_q.lv_s3[i]) begin
                s_d.lv_acc[i] = s_q.lv_s3[i];
            end
        end
        wm = write_lanes(sfr_addr, sfr_page, sfr_wr, sfr_bit_wr) & scf_pkg::WRITE_MASK;
        wv = sfr_wr ? sfr_wdata : {8{sfr_wdata[0]}};
        // declined address mutes slave events until the next start
        slave_ok = !s_q.ignore_slave;
        addr_ev = ev[scf_pkg::EV_ADDR_RX] && slave_ok;
        brx_ev = ev[scf_pkg::EV_BYTE_RX] && (slave_ok || r[scf_pkg::MASTER_BIT]);
        stop_loss = ev[scf_pkg::EV_STOP_DET] && r[scf_pkg::MASTER_BIT];
        lost = (ev[scf_pkg::EV_RSTART_DET] && r[scf_pkg::MASTER_BIT]
                && !r[scf_pkg::START_BIT])
            || ev[scf_pkg::EV_SCL_LOST]
            || ev[scf_pkg::EV_SDA_LOST]
            || stop_loss;
        if (ev[scf_pkg::EV_ADDR_NACK]) begin
            s_d.ignore_slave = 1'b1;
        end else if (ev[scf_pkg::EV_START_DET]) begin
            s_d.ignore_slave = 1'b0;
        end
        // remember a data write until the next frame begins
        if (data_reg_wr) begin
            s_d.data_written = 1'b1;
        end else if (ev[scf_pkg::EV_FRAME_BEGIN]) begin
            s_d.data_written = 1'b0;
        end
        // software writes first, hardware sets override so no event is lost
        r = (r & ~wm) | (wv & wm);
        sw_si_clr = wm[scf_pkg::EVENT_BIT] && !wv[scf_pkg::EVENT_BIT];
        // master role
        if (ev[scf_pkg::EV_STOP_GEN] || lost) begin
            r[scf_pkg::MASTER_BIT] = 1'b0;
        end
        if (ev[scf_pkg::EV_START_GEN]) begin
            r[scf_pkg::MASTER_BIT] = 1'b1;
        end
        // transmit direction
        if (ev[scf_pkg::EV_START_DET] || lost
            || (ev[scf_pkg::EV_FRAME_BEGIN] && !s_q.data_written)) begin
            r[scf_pkg::TXDIR_BIT] = 1'b0;
        end
        if (ev[scf_pkg::EV_START_GEN]
            || (ev[scf_pkg::EV_FRAME_BEGIN] && s_q.data_written)) begin
            r[scf_pkg::TXDIR_BIT] = 1'b1;
        end
        // start flag, never cleared by hardware
        if (addr_ev) begin
            r[scf_pkg::START_BIT] = 1'b1;
        end
        // stop flag
        if (ev[scf_pkg::EV_STOP_GEN]) begin
            r[scf_pkg::STOP_BIT] = 1'b0;
        end
        if ((ev[scf_pkg::EV_STOP_DET] && s_q.lv_acc[scf_pkg::LV_ADDRESSED] && slave_ok)
            || stop_loss) begin
            r[scf_pkg::STOP_BIT] = 1'b1;
        end
        // ack request only in software ack mode
        if (ev[scf_pkg::EV_ACK_DONE]) begin
            r[scf_pkg::ACKRQ_BIT] = 1'b0;
        end
        if (brx_ev && !hardware_ack_enable) begin
            r[scf_pkg::ACKRQ_BIT] = 1'b1;
        end
        // arbitration lost follows every event-flag clear
        if (sw_si_clr && s_q.port_b_control_reg[scf_pkg::EVENT_BIT]) begin
            r[scf_pkg::ARBL_BIT] = 1'b0;
        end
        if (lost) begin
            r[scf_pkg::ARBL_BIT] = 1'b1;
        end
        // received acknowledge level as transmitter
        if (ev[scf_pkg::EV_BYTE_TX_ACK]) begin
            r[scf_pkg::ACK_BIT] = s_q.lv_acc[scf_pkg::LV_ACK_LOW];
        end
        // event flag
        si_set = ev[scf_pkg::EV_START_GEN] || lost || ev[scf_pkg::EV_BYTE_TX_ACK]
            || brx_ev || addr_ev
            || (ev[scf_pkg::EV_STOP_DET] && s_q.lv_acc[scf_pkg::LV_ADDRESSED] && slave_ok);
        if (si_set) begin
            r[scf_pkg::EVENT_BIT] = 1'b1;
        end
        s_d.port_b_control_reg = r;
        // registered read data and interrupt request
        if (sfr_rd && sfr_page == scf_pkg::CTRL_PAGE && sfr_addr == scf_pkg::CTRL_ADDR) begin
            s_d.rdata = s_q.port_b_control_reg;
        end else begin
            s_d.rdata = 8'h00;
        end
        s_d.irq = r[scf_pkg::EVENT_BIT];
    end

    // system-domain register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.port_b_control_reg <= scf_pkg::CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // levels handed to the engine
    always_comb begin
        ctl_level = '0;
        ctl_level[scf_pkg::CT_HOLD_SCL] = s_q.port_b_control_reg[scf_pkg::EVENT_BIT];
        ctl_level[scf_pkg::CT_START_REQ] = s_q.port_b_control_reg[scf_pkg::START_BIT];
        ctl_level[scf_pkg::CT_STOP_REQ] = s_q.port_b_control_reg[scf_pkg::STOP_BIT]
            && s_q.port_b_control_reg[scf_pkg::MASTER_BIT];
        ctl_level[scf_pkg::CT_ACK_OUT] = s_q.port_b_control_reg[scf_pkg::ACK_BIT];
        ctl_level[scf_pkg::CT_HW_ACK] = hardware_ack_enable;
    end

    // link-domain next state: pulses become toggles, levels resync
    always_comb begin
        l_d = l_q;
        l_d.tog = l_q.tog ^ link_event;
        l_d.ct_s1 = ctl_level;
        l_d.ct_s2 = l_q.ct_s1;
        l_d.ct_s3 = l_q.ct_s2;
        for (int i = 0; i < NCT; i++) begin
            if (l_q.ct_s2[i] == l_q.ct_s3[i]) begin
                l_d.ct_out[i] = l_q.ct_s3[i];
            end
        end
    end

    // link-domain register
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // outputs straight from flops
    assign sfr_rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign link_hold_scl = l_q.ct_out[scf_pkg::CT_HOLD_SCL];
    assign link_start_req = l_q.ct_out[scf_pkg::CT_START_REQ];
    assign link_stop_req = l_q.ct_out[scf_pkg::CT_STOP_REQ];
    assign link_ack_out = l_q.ct_out[scf_pkg::CT_ACK_OUT];
    assign link_hw_ack = l_q.ct_out[scf_pkg::CT_HW_ACK];

    // checks
    property p_master_set;
        @(posedge clk) disable iff (!rstn)
        ev[scf_pkg::EV_START_GEN] |=> s_q.port_b_control_reg[scf_pkg::MASTER_BIT];
    endproperty
    a_master_set: assert property (p_master_set) else $error("master flag not set");

    property p_master_clr;
        @(posedge clk) disable iff (!rstn)
        ev[scf_pkg::EV_STOP_GEN] && !ev[scf_pkg::EV_START_GEN]
        |=> !s_q.port_b_control_reg[scf_pkg::MASTER_BIT];
    endproperty
    a_master_clr: assert property (p_master_clr) else $error("master flag not cleared");

    property p_start_sticky;
        @(posedge clk) disable iff (!rstn)
        s_q.port_b_control_reg[scf_pkg::START_BIT] && !sfr_wr && !sfr_bit_wr
        |=> s_q.port_b_control_reg[scf_pkg::START_BIT];
    endproperty
    a_start_sticky: assert property (p_start_sticky) else $error("start flag lost");

    property p_ro_bits;
        @(posedge clk) disable iff (!rstn)
        sfr_wr && ev == '0 |=> s_q.port_b_control_reg[7:6] == $past(s_q.port_b_control_reg[7:6])
            && s_q.port_b_control_reg[3] == $past(s_q.port_b_control_reg[3])
            // an event-flag clear by software also clears the loss flag
            && (s_q.port_b_control_reg[2] == $past(s_q.port_b_control_reg[2])
                || !$past(sfr_wdata[0]));
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only bit written");

    property p_arbl_event;
        @(posedge clk) disable iff (!rstn)
        ev[scf_pkg::EV_SDA_LOST] |=> s_q.port_b_control_reg[scf_pkg::ARBL_BIT]
            && s_q.port_b_control_reg[scf_pkg::EVENT_BIT] && !s_q.port_b_control_reg[7];
    endproperty
    a_arbl_event: assert property (p_arbl_event) else $error("loss not flagged");

    property p_arbl_clr;
        @(posedge clk) disable iff (!rstn)
        $fell(s_q.port_b_control_reg[scf_pkg::EVENT_BIT])
        |-> !s_q.port_b_control_reg[scf_pkg::ARBL_BIT];
    endproperty
    a_arbl_clr: assert property (p_arbl_clr) else $error("loss flag outlived event clear");

    property p_event_sticky;
        @(posedge clk) disable iff (!rstn)
        s_q.port_b_control_reg[scf_pkg::EVENT_BIT] && !sfr_wr && !sfr_bit_wr
        |=> s_q.port_b_control_reg[scf_pkg::EVENT_BIT];
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("event flag cleared by hw");

    property p_irq;
        @(posedge clk) disable iff (!rstn)
        irq == s_q.port_b_control_reg[scf_pkg::EVENT_BIT];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not following event");

    property p_hold_scl;
        @(posedge link_clk) disable iff (!link_rstn)
        $rose(l_q.ct_s3[scf_pkg::CT_HOLD_SCL]) ##0 l_q.ct_s2[scf_pkg::CT_HOLD_SCL]
        |=> link_hold_scl;
    endproperty
    a_hold_scl: assert property (p_hold_scl) else $error("clock hold not passed");

    property p_ackrq_hw;
        @(posedge clk) disable iff (!rstn)
        ev[scf_pkg::EV_BYTE_RX] && hardware_ack_enable && !s_q.port_b_control_reg[3]
        |=> !s_q.port_b_control_reg[scf_pkg::ACKRQ_BIT];
    endproperty
    a_ackrq_hw: assert property (p_ackrq_hw) else $error("ack request in hw mode");

    c_start: cover property (@(posedge clk) disable iff (!rstn) ev[scf_pkg::EV_START_GEN]);
    c_lost: cover property (@(posedge clk) disable iff (!rstn)
        $rose(s_q.port_b_control_reg[scf_pkg::ARBL_BIT]));
    c_clear: cover property (@(posedge clk) disable iff (!rstn)
        $fell(s_q.port_b_control_reg[scf_pkg::EVENT_BIT]));
endmodule

// [sim/scf_engine_model.sv]
// link-side engine model: event pulses on the link clock
`timescale 1ns/1ps
module scf_engine_model (
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_rstn,
    // levels from the flag register
    input wire logic link_hold_scl,
    input wire logic link_start_req,
    input wire logic link_stop_req,
    // event pulses, one link cycle each
    output logic [12:0] link_event
);
    logic [12:0] man_ev = '0;
    logic [12:0] auto_ev = '0;
    logic start_done = 1'b0;
    assign link_event = man_ev | auto_ev;
    // answers start and stop requests the way a bus engine would
    always @(posedge link_clk) begin
        auto_ev <= '0;
        if (!link_rstn || !link_start_req) begin
            start_done <= 1'b0;
        end else if (!start_done && !link_hold_scl) begin
            auto_ev[0] <= 1'b1;
            start_done <= 1'b1;
        end
        // pending stop goes out right after the ack cycle
        if (link_rstn && man_ev[8] && link_stop_req) begin
            auto_ev[1] <= 1'b1;
        end
    end
    // a stalled bus produces no events until the clock line is let go or 200 link cycles pass
    task automatic fire(input int idx);
        int n;
        n = 0;
        while (link_hold_scl && n < 200) begin
            @(posedge link_clk);
            n++;
        end
        @(posedge link_clk);
        man_ev[idx] <= 1'b1;
        @(posedge link_clk);
        man_ev <= '0;
    endtask
endmodule

// [sim/tb.sv]
// testbench for the port b control and status flag register
`timescale 1ns/1ps
module tb;
    logic clk, rstn, link_clk, link_rstn;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0] sfr_page;
    logic sfr_wr, sfr_bit_wr, sfr_rd, irq, data_reg_wr, hw_ack;
    logic [12:0] link_event;
    logic [1:0] link_level;
    logic hold, start_req, stop_req, ack_out, hw_ack_out;
    int err_count = 0;
    int n_compared = 0;
    int arb_ev[4] = '{4, 9, 10, 5};

    scf_ctrl dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
        .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .irq(irq), .data_reg_wr(data_reg_wr),
        .hardware_ack_enable(hw_ack), .link_clk(link_clk), .link_rstn(link_rstn),
        .link_event(link_event), .link_level(link_level), .link_hold_scl(hold),
        .link_start_req(start_req), .link_stop_req(stop_req), .link_ack_out(ack_out),
        .link_hw_ack(hw_ack_out));
    scf_engine_model eng (.link_clk(link_clk), .link_rstn(link_rstn),
        .link_hold_scl(hold), .link_start_req(start_req), .link_stop_req(stop_req),
        .link_event(link_event));

    // two unrelated clocks
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // byte write, or bit write with the bit address in a
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = !bw;
        sfr_bit_wr = bw;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
    endtask

    // read data is registered, so it is looked at one cycle later
    task automatic chk(input logic [7:0] m, input logic [7:0] e, input logic [3:0] pg = 4'hF);
        @(negedge clk);
        sfr_addr = 8'hC0;
        sfr_page = pg;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_page = 4'hF;
        cmp("ctrl_reg", e, sfr_rdata & m);
    endtask

    // software frees the bus first, as a real handler would
    task automatic ev(input int i);
        wr(8'hC0, 8'h00, 1'b1);
        eng.fire(i);
        repeat (12) @(negedge clk);
    endtask

    initial begin
        #200000;
        err_count++;
        $display("MISMATCH watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        {rstn, link_rstn, sfr_wr, sfr_bit_wr, sfr_rd, data_reg_wr, hw_ack} = '0;
        {sfr_addr, sfr_wdata, link_level} = '0;
        sfr_page = 4'hF;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        link_rstn = 1'b1;
        chk(8'hFF, 8'h00);
        wr(8'hC0, 8'hDF, 1'b0);
        chk(8'hFF, 8'h13);
        cmp("irq", 8'h01, {7'h00, irq});
        chk(8'hFF, 8'h00, 4'h0);
        wr(8'hC0, 8'h00, 1'b0);
        chk(8'hFF, 8'h00);
        cmp("irq", 8'h00, {7'h00, irq});
        cmp("hold", 8'h00, {7'h00, hold});
        // start request answered by the engine
        wr(8'hC5, 8'h01, 1'b1);
        repeat (20) @(negedge clk);
        chk(8'hFF, 8'hE1);
        cmp("hold", 8'h01, {7'h00, hold});
        wr(8'hC5, 8'h00, 1'b1);
        wr(8'hC4, 8'h01, 1'b1);
        repeat (8) @(negedge clk);
        cmp("stop_req", 8'h01, {7'h00, stop_req});
        ev(8);
        chk(8'h90, 8'h00);
        cmp("stop_req", 8'h00, {7'h00, stop_req});
        // every way of losing arbitration
        foreach (arb_ev[k]) begin
            wr(8'hC0, 8'h00, 1'b0);
            ev(0);
            ev(arb_ev[k]);
            chk(8'h85, 8'h05);
            wr(8'hC0, 8'h00, 1'b1);
            chk(8'h04, 8'h00);
        end
        chk(8'h10, 8'h10);
        wr(8'hC0, 8'h00, 1'b0);
        ev(6);
        chk(8'h09, 8'h09);
        wr(8'hC1, 8'h01, 1'b1);
        repeat (8) @(negedge clk);
        cmp("ack_out", 8'h01, {7'h00, ack_out});
        ev(8);
        chk(8'h08, 8'h00);
        hw_ack = 1'b1;
        ev(6);
        chk(8'h09, 8'h01);
        cmp("hw_ack", 8'h01, {7'h00, hw_ack_out});
        // incoming ack level, low then high
        link_level = 2'b01;
        ev(7);
        chk(8'h03, 8'h03);
        link_level = 2'b00;
        ev(7);
        chk(8'h03, 8'h01);
        // addressed as slave, then stop
        link_level = 2'b10;
        ev(3);
        chk(8'h21, 8'h21);
        // drop the start flag first, or freeing the bus would start a master frame
        wr(8'hC5, 8'h00, 1'b1);
        ev(5);
        chk(8'hB5, 8'h11);
        wr(8'hC0, 8'h00, 1'b0);
        link_level = 2'b00;
        ev(11);
        ev(3);
        chk(8'h21, 8'h00);
        ev(2);
        ev(3);
        chk(8'h21, 8'h21);
        wr(8'hC0, 8'h00, 1'b0);
        @(negedge clk);
        data_reg_wr = 1'b1;
        @(negedge clk);
        data_reg_wr = 1'b0;
        ev(12);
        chk(8'h40, 8'h40);
        ev(12);
        chk(8'h40, 8'h00);
        end_sim();
    end
endmodule
